/* File: rtl/pfodl_pin_drive.sv */
// Per-pin output selection: fault force, generator or manual level
`timescale 1ns/1ps
module pfodl_pin_drive
    import pfodl_pkg::*;
#(
    parameter int PINS = N_PINS
)
(
    input wire logic [PINS-1:0] gen_level,
    input wire logic [PINS-1:0] drive_sel,
    input wire logic [PINS-1:0] manual_level,
    input wire logic [PINS-1:0] fault_force,
    input wire logic [PINS-1:0] fault_value,
    output logic [PINS-1:0] pin_level
);
    generate
        if (PINS != N_PINS)
        begin : g_bad
            $error("pfodl_pin_drive serves exactly six pins");
        end
        for (genvar i = 0; i < PINS; i++)
        begin : g_pin
            always_comb
            begin
                if (fault_force[i])
                    pin_level[i] = fault_value[i];
                else if (drive_sel[i])
                    pin_level[i] = gen_level[i];
                else
                    pin_level[i] = manual_level[i];
            end
        end
    endgenerate
endmodule // pfodl_pin_drive

/* File: rtl/pfodl_pkg.sv */
// Register map, field layout and reset values of the fault-B/override block
package pfodl_pkg;
    localparam int N_PAIRS = 3;
    localparam int N_PINS = 6;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_FAULT_B = 8'h00;
    localparam logic [7:0] OFS_OVERRIDE = 8'h04;
    localparam logic [7:0] OFS_DUTY1 = 8'h08;
    localparam logic [7:0] OFS_DUTY2 = 8'h0c;
    localparam logic [7:0] OFS_DUTY3 = 8'h10;
    localparam logic [7:0] OFS_KEY = 8'h14;
    localparam logic [7:0] OFS_CON_ONE = 8'h18;
    localparam logic [7:0] OFS_FAULT_A = 8'h1c;
    localparam logic [7:0] OFS_CON_TWO = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam int SEL_FB = 0;
    localparam int SEL_OVD = 1;
    localparam int SEL_DC1 = 2;
    localparam int SEL_KEY = 5;
    localparam int SEL_CON1 = 6;
    localparam int SEL_FA = 7;
    localparam int SEL_CON2 = 8;
    localparam int SEL_STAT = 9;
    localparam int N_SEL = 10;
    localparam logic [15:0] FB_RESET = 16'h0007;
    localparam logic [15:0] FB_MASK = 16'h3f87;
    localparam logic [15:0] OVD_RESET = 16'h3f00;
    localparam logic [15:0] OVD_MASK = 16'h3f3f;
    localparam logic [15:0] CON1_RESET = 16'h0000;
    localparam logic [15:0] CON1_MASK = 16'h0777;
    localparam logic [15:0] CON2_RESET = 16'h0000;
    localparam logic [15:0] CON2_MASK = 16'h0006;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    localparam logic [15:0] KEY_RESET = 16'h0000;
    localparam logic [15:0] FULL_MASK = 16'hffff;
    localparam int FB_OVR_LSB = 8;
    localparam int FB_MODE_BIT = 7;
    localparam int FB_EN_LSB = 0;
    localparam int OVD_SEL_LSB = 8;
    localparam int OVD_MAN_LSB = 0;
    localparam int CON2_IUE_BIT = 2;
    localparam int CON2_OVERRIDE_TIMEBASE_SYNC_BIT = 1;
    localparam int ST_OPEN_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_CBC_BIT = 2;
    localparam int ST_LOCK_BIT = 3;
    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_OPEN = 3'b100
    } pfodl_key_t;
endpackage

/* File: rtl/pfodl_top.sv */
// Fault-B, manual override, duty and write-lock block with APB slave
// Overview of operation
// - An asserted second fault input forces each enabled pin to its override value.
// - With cycle mode set the fault override holds only until a period start without fault.
// - With cycle mode clear a fault latches the pins at their override values.
// - Three pair enable bits put each pair under fault control and reset to one.
// - The second fault input is enabled after reset and software must clear it if unused.
// - A set drive select bit gives the pin to the generator, cleared gives manual, reset one.
// - With drive select clear the pin follows its manual level bit, which resets to zero.
// - Three 16-bit duty registers reset to zero and supply each pair's compare value.
// - With the lock setting one, protected registers take writes only after the key.
// - With the lock setting zero, protected registers take writes at any time.
// - The key register is 16-bit read/write, resets to zero and is checked for the key.
// - Unimplemented bits of fault and override registers read zero and ignore writes.
// - Override changes apply at period start with sync set, else on the next cycle.
// - Duty writes apply at once with immediate update set, else at period start.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pfodl_top
    import pfodl_pkg::*;
#(
    parameter logic [15:0] KEY_FIRST = 16'h00a5,
    parameter logic [15:0] KEY_SECOND = 16'h005a
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_lock_config,
    input wire logic second_fault_input,
    input wire logic pwm_period_sync,
    input wire logic [N_PAIRS-1:0] gen_high,
    input wire logic [N_PAIRS-1:0] gen_low,
    output logic [N_PAIRS-1:0] high_side_output,
    output logic [N_PAIRS-1:0] low_side_output,
    output logic [REG_W-1:0] duty_active_pair1,
    output logic [REG_W-1:0] duty_active_pair2,
    output logic [REG_W-1:0] duty_active_pair3
);
    generate
        if (KEY_FIRST == KEY_SECOND)
        begin : g_bad_key
            $error("pfodl_top key words must differ");
        end
    endgenerate

    // Address decode to a one-hot select
    function automatic logic [N_SEL-1:0] decode(input logic [ADDR_W-1:0] a);
        logic [N_SEL-1:0] s;
        s = '0;
        if (a == OFS_FAULT_B)
            s[SEL_FB] = 1'b1;
        else if (a == OFS_OVERRIDE)
            s[SEL_OVD] = 1'b1;
        else if (a == OFS_DUTY1)
            s[SEL_DC1] = 1'b1;
        else if (a == OFS_DUTY2)
            s[SEL_DC1+1] = 1'b1;
        else if (a == OFS_DUTY3)
            s[SEL_DC1+2] = 1'b1;
        else if (a == OFS_KEY)
            s[SEL_KEY] = 1'b1;
        else if (a == OFS_CON_ONE)
            s[SEL_CON1] = 1'b1;
        else if (a == OFS_FAULT_A)
            s[SEL_FA] = 1'b1;
        else if (a == OFS_CON_TWO)
            s[SEL_CON2] = 1'b1;
        else if (a == OFS_STATUS)
            s[SEL_STAT] = 1'b1;
        return s;
    endfunction

    // Byte-lane merge with the implemented-bit mask
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] st, input logic [15:0] m);
        logic [15:0] nv;
        nv[15:8] = st[1] ? wd[15:8] : old[15:8];
        nv[7:0] = st[0] ? wd[7:0] : old[7:0];
        return nv & m;
    endfunction

    logic [N_SEL-1:0] sel;
    logic wr_go;
    logic prot_ok;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [15:0] rd_mux;
    logic [15:0] fb_q;
    logic [15:0] fa_q;
    logic [15:0] con1_q;
    logic [15:0] con2_q;
    logic [15:0] ovd_q;
    logic [15:0] ovd_act_q;
    logic [15:0] key_q;
    logic [15:0] duty_q [N_PAIRS];
    logic [15:0] duty_act_q [N_PAIRS];
    pfodl_key_t key_state_q;
    logic lock_cfg_q;
    logic lock_seen_q;
    logic fault_cbc_q;
    logic fault_latch_q;
    logic fault_on;
    logic fb_wr;
    logic [N_PAIRS-1:0] pair_fault;
    logic [N_PINS-1:0] pin_force;
    logic [N_PINS-1:0] gen_level;
    logic [N_PINS-1:0] pin_level;
    logic first_q;

    assign sel = decode(paddr);
    assign wr_go = psel & penable & pwrite & pready_q;
    assign prot_ok = !lock_cfg_q || (key_state_q == KEY_OPEN);
    assign fb_wr = wr_go & sel[SEL_FB] & prot_ok;

    // APB answer: one wait state, data and error from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else if (psel && penable && !pready_q)
        begin
            pready_q <= 1'b1;
            pslverr_q <= ~(|sel);
            prdata_q <= {16'h0000, rd_mux};
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // Read mux; masks keep unimplemented bits at zero
    always_comb
    begin
        rd_mux = '0;
        if (sel[SEL_FB])
            rd_mux = fb_q & FB_MASK;
        else if (sel[SEL_OVD])
            rd_mux = ovd_q & OVD_MASK;
        else if (sel[SEL_DC1])
            rd_mux = duty_q[0];
        else if (sel[SEL_DC1+1])
            rd_mux = duty_q[1];
        else if (sel[SEL_DC1+2])
            rd_mux = duty_q[2];
        else if (sel[SEL_KEY])
            rd_mux = key_q;
        else if (sel[SEL_CON1])
            rd_mux = con1_q;
        else if (sel[SEL_FA])
            rd_mux = fa_q;
        else if (sel[SEL_CON2])
            rd_mux = con2_q;
        else if (sel[SEL_STAT])
        begin
            rd_mux[ST_OPEN_BIT] = key_state_q == KEY_OPEN;
            rd_mux[ST_LATCH_BIT] = fault_latch_q;
            rd_mux[ST_CBC_BIT] = fault_cbc_q;
            rd_mux[ST_LOCK_BIT] = lock_cfg_q;
        end
    end

    // Lock setting is caught on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_cfg_q <= 1'b1;
            lock_seen_q <= 1'b0;
        end
        else if (!lock_seen_q)
        begin
            lock_cfg_q <= write_lock_config;
            lock_seen_q <= 1'b1;
        end
    end

    // Key register storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            key_q <= KEY_RESET;
        else if (wr_go && sel[SEL_KEY])
            key_q <= merge(key_q, pwdata, pstrb, FULL_MASK);
    end

    // Unlock sequence: two key words in order, one protected write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            key_state_q <= KEY_IDLE;
        else if (wr_go && sel[SEL_KEY])
        begin
            case (key_state_q)
                KEY_IDLE:
                    key_state_q <= (pwdata[15:0] == KEY_FIRST) ?
                        KEY_HALF : KEY_IDLE;
                KEY_HALF:
                    key_state_q <= (pwdata[15:0] == KEY_SECOND) ?
                        KEY_OPEN : KEY_IDLE;
                default:
                    key_state_q <= KEY_IDLE;
            endcase
        end
        else if (wr_go && (sel[SEL_FB] || sel[SEL_FA] || sel[SEL_CON1]))
            key_state_q <= KEY_IDLE;
    end

    // Protected registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fb_q <= FB_RESET;
        else if (fb_wr)
            fb_q <= merge(fb_q, pwdata, pstrb, FB_MASK);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fa_q <= FB_RESET;
        else if (wr_go && sel[SEL_FA] && prot_ok)
            fa_q <= merge(fa_q, pwdata, pstrb, FB_MASK);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            con1_q <= CON1_RESET;
        else if (wr_go && sel[SEL_CON1] && prot_ok)
            con1_q <= merge(con1_q, pwdata, pstrb, CON1_MASK);
    end

    // Unprotected control: immediate update and override sync
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            con2_q <= CON2_RESET;
        else if (wr_go && sel[SEL_CON2])
            con2_q <= merge(con2_q, pwdata, pstrb, CON2_MASK);
    end

    // Override register and its active copy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovd_q <= OVD_RESET;
        else if (wr_go && sel[SEL_OVD])
            ovd_q <= merge(ovd_q, pwdata, pstrb, OVD_MASK);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovd_act_q <= OVD_RESET;
        else if (!con2_q[CON2_OVERRIDE_TIMEBASE_SYNC_BIT] || pwm_period_sync)
            ovd_act_q <= ovd_q;
    end

    // Duty registers and their active compare values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < N_PAIRS; i++)
                duty_q[i] <= DUTY_RESET;
        end
        else
        begin
            for (int i = 0; i < N_PAIRS; i++)
                if (wr_go && sel[SEL_DC1+i])
                    duty_q[i] <= merge(duty_q[i], pwdata, pstrb,
                        FULL_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < N_PAIRS; i++)
                duty_act_q[i] <= DUTY_RESET;
        end
        else if (con2_q[CON2_IUE_BIT] || pwm_period_sync)
        begin
            for (int i = 0; i < N_PAIRS; i++)
                duty_act_q[i] <= duty_q[i];
        end
    end
    assign duty_active_pair1 = duty_act_q[0];
    assign duty_active_pair2 = duty_act_q[1];
    assign duty_active_pair3 = duty_act_q[2];

    // Cycle-by-cycle hold: cleared at a period start with no fault
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_cbc_q <= 1'b0;
        else if (second_fault_input)
            fault_cbc_q <= 1'b1;
        else if (pwm_period_sync)
            fault_cbc_q <= 1'b0;
    end

    // Latched fault: cleared by an accepted fault control write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_latch_q <= 1'b0;
        else if (second_fault_input)
            fault_latch_q <= 1'b1;
        else if (fb_wr)
            fault_latch_q <= 1'b0;
    end

    assign fault_on = second_fault_input |
        (fb_q[FB_MODE_BIT] ? fault_cbc_q : fault_latch_q);
    assign pair_fault = fb_q[FB_EN_LSB +: N_PAIRS] & {N_PAIRS{fault_on}};
    generate
        for (genvar p = 0; p < N_PAIRS; p++)
        begin : g_pair
            assign pin_force[2*p +: 2] = {2{pair_fault[p]}};
            assign gen_level[2*p] = gen_low[p];
            assign gen_level[2*p+1] = gen_high[p];
        end
    endgenerate

    pfodl_pin_drive #(
        .PINS(N_PINS)
    ) u_pin_drive (
        .gen_level(gen_level),
        .drive_sel(ovd_act_q[OVD_SEL_LSB +: N_PINS]),
        .manual_level(ovd_act_q[OVD_MAN_LSB +: N_PINS]),
        .fault_force(pin_force),
        .fault_value(fb_q[FB_OVR_LSB +: N_PINS]),
        .pin_level(pin_level)
    );

    // Registered pin outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_side_output <= '0;
            low_side_output <= '0;
        end
        else
        begin
            for (int p = 0; p < N_PAIRS; p++)
            begin
                high_side_output[p] <= pin_level[2*p+1];
                low_side_output[p] <= pin_level[2*p];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence key_first_s;
        wr_go && sel[SEL_KEY] && key_state_q == KEY_IDLE &&
            pwdata[15:0] == KEY_FIRST;
    endsequence
    sequence key_second_s;
        wr_go && sel[SEL_KEY] && key_state_q == KEY_HALF &&
            pwdata[15:0] == KEY_SECOND;
    endsequence
    sequence locked_fb_write_s;
        wr_go && sel[SEL_FB] && lock_cfg_q && key_state_q != KEY_OPEN;
    endsequence

    fault_force_a: assert property (
        second_fault_input && fb_q[FB_EN_LSB] |=>
            high_side_output[0] == $past(fb_q[FB_OVR_LSB+1]))
        else $error("enabled pair not forced to override value");
    cycle_release_a: assert property (
        fb_q[FB_MODE_BIT] && !second_fault_input && pwm_period_sync &&
            !fb_wr |=> !fault_cbc_q && (fault_on == second_fault_input))
        else $error("cycle fault not released at period start");
    latch_hold_a: assert property (
        !fb_q[FB_MODE_BIT] && second_fault_input ##1 !fb_wr
            |-> fault_latch_q && fault_on)
        else $error("latched fault did not hold");
    reset_enable_a: assert property (
        first_q |-> fb_q == FB_RESET && ovd_q == OVD_RESET &&
            key_q == KEY_RESET)
        else $error("fault enables or override not at reset value");
    manual_drive_a: assert property (
        !ovd_act_q[OVD_SEL_LSB] && !pair_fault[0] |=>
            low_side_output[0] == $past(ovd_act_q[OVD_MAN_LSB]))
        else $error("manual level not driven");
    generator_pass_a: assert property (
        ovd_act_q[OVD_SEL_LSB+1] && !pair_fault[0] |=>
            high_side_output[0] == $past(gen_high[0]))
        else $error("generator level not passed");
    duty_hold_a: assert property (
        !con2_q[CON2_IUE_BIT] && !pwm_period_sync |=>
            $stable(duty_active_pair2))
        else $error("duty changed outside period start");
    duty_write_a: assert property (
        wr_go && sel[SEL_DC1] && pstrb[1:0] == 2'b11 |=>
            duty_q[0] == $past(pwdata[15:0]))
        else $error("duty register write lost");
    unlock_seq_a: assert property (
        key_first_s |=> key_state_q == KEY_HALF)
        else $error("first key word not recorded");
    unlock_open_a: assert property (
        key_second_s |=> key_state_q == KEY_OPEN)
        else $error("key sequence did not unlock");
    locked_ignore_a: assert property (
        locked_fb_write_s |=> $stable(fb_q))
        else $error("locked fault control accepted a write");
    open_write_a: assert property (
        wr_go && sel[SEL_FB] && !lock_cfg_q && pstrb[1:0] == 2'b11 |=>
            fb_q == ($past(pwdata[15:0]) & FB_MASK))
        else $error("unlocked fault control write lost");
    reserved_zero_a: assert property (
        pready_q && sel[SEL_FB] |-> prdata_q[15:14] == 2'b00 &&
            prdata_q[6:3] == 4'h0)
        else $error("reserved fault control bits read nonzero");
    override_now_a: assert property (
        !con2_q[CON2_OVERRIDE_TIMEBASE_SYNC_BIT] && !pwm_period_sync |=>
            ovd_act_q == $past(ovd_q))
        else $error("override not applied on next cycle");
endmodule // pfodl_top

/* File: test/pfodl_stage_model.sv */
// Behavioural power stage, time base and fault source facing the block
`timescale 1ns/1ps
module pfodl_stage_model
    import pfodl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic fault_req,
    output logic second_fault_input,
    output logic pwm_period_sync,
    output logic [N_PAIRS-1:0] gen_high,
    output logic [N_PAIRS-1:0] gen_low
);
    logic [2:0] cnt_q;
    assign gen_high = 3'h5;
    assign gen_low = 3'h2;
    // Fault source from outside, registered one cycle onto the dedicated fault pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            second_fault_input <= 1'b0;
        else
            second_fault_input <= fault_req;
    end
    // Period start every eight cycles while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 3'h0;
        else
            cnt_q <= cnt_q + 3'h1;
    end
    assign pwm_period_sync = run && (cnt_q == 3'h7);
endmodule // pfodl_stage_model

/* File: test/test_pfodl_top.sv */
// Self-checking bench for the fault-B, override, duty and lock block
`timescale 1ns/1ps
module test_pfodl_top;
    import pfodl_pkg::*;
    localparam logic [15:0] K1 = 16'h00a5;
    localparam logic [15:0] K2 = 16'h005a;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lock_cfg = 1'b0;
    logic run = 1'b1;
    logic fault_req = 1'b0;
    logic sfi;
    logic psync;
    logic [2:0] gh, gl, hso, lso;
    logic [15:0] da1, da2, da3;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_checks = 0;

    always #20 pclk = ~pclk;

    pfodl_top #(.KEY_FIRST(K1), .KEY_SECOND(K2)) u_pfodl_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_lock_config(lock_cfg), .second_fault_input(sfi),
        .pwm_period_sync(psync), .gen_high(gh), .gen_low(gl),
        .high_side_output(hso), .low_side_output(lso),
        .duty_active_pair1(da1), .duty_active_pair2(da2),
        .duty_active_pair3(da3));

    pfodl_stage_model u_pfodl_stage_model (
        .pclk(pclk), .presetn(presetn), .run(run), .fault_req(fault_req),
        .second_fault_input(sfi), .pwm_period_sync(psync),
        .gen_high(gh), .gen_low(gl));

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= 4'h3;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            err_total++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        check(what, rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic pin_chk(input logic [5:0] exp);
        check("pins", {hso[2], lso[2], hso[1], lso[1], hso[0], lso[0]}, exp);
    endtask

    task automatic set_fault(input logic v);
        @(posedge pclk);
        fault_req <= v;
    endtask

    task automatic do_reset(input logic lk);
        @(posedge pclk);
        presetn <= 1'b0;
        lock_cfg <= lk;
        settle(16);
        presetn <= 1'b1;
        settle(2);
    endtask

    task automatic t_reset;
        rdchk("fb", OFS_FAULT_B, 32'h0007);
        rdchk("ovd", OFS_OVERRIDE, 32'h3f00);
        rdchk("dc1", OFS_DUTY1, 32'h0);
        rdchk("dc2", OFS_DUTY2, 32'h0);
        rdchk("dc3", OFS_DUTY3, 32'h0);
        rdchk("key", OFS_KEY, 32'h0);
        pin_chk(6'h26);
        apb(1'b0, 8'h30, 16'h0000);
        check("unmapped", {rd[30:0], er}, 32'h1);
    endtask

    task automatic t_bits;
        wr(OFS_FAULT_B, 16'hffff);
        rdchk("fb", OFS_FAULT_B, 32'h3f87);
        wr(OFS_OVERRIDE, 16'hffff);
        rdchk("ovd", OFS_OVERRIDE, 32'h3f3f);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'(OFS_DUTY1 + 4 * i), 16'(16'hf00f + i));
            rdchk("dc", 8'(OFS_DUTY1 + 4 * i), 32'(16'hf00f + i));
        end
        wr(OFS_KEY, 16'h1234);
        rdchk("key", OFS_KEY, 32'h1234);
        wr(OFS_FAULT_B, 16'h0007);
        wr(OFS_OVERRIDE, 16'h3f00);
    endtask

    task automatic t_manual;
        wr(OFS_OVERRIDE, 16'h0015);
        settle(3);
        pin_chk(6'h15);
        wr(OFS_OVERRIDE, 16'h0c30);
        settle(3);
        pin_chk(6'h34);
        wr(OFS_OVERRIDE, 16'h3f00);
        settle(3);
        pin_chk(6'h26);
    endtask

    task automatic t_fault;
        wr(OFS_FAULT_B, 16'h2a07);
        set_fault(1'b1);
        settle(3);
        pin_chk(6'h2a);
        set_fault(1'b0);
        settle(12);
        pin_chk(6'h2a);
        wr(OFS_FAULT_B, 16'h2a07);
        settle(3);
        pin_chk(6'h26);
        wr(OFS_FAULT_B, 16'h3f81);
        set_fault(1'b1);
        settle(10);
        pin_chk(6'h27);
        set_fault(1'b0);
        settle(12);
        pin_chk(6'h26);
        wr(OFS_FAULT_B, 16'h3f00);
        set_fault(1'b1);
        settle(3);
        pin_chk(6'h26);
        set_fault(1'b0);
    endtask

    task automatic t_sync;
        @(posedge pclk);
        run <= 1'b0;
        wr(OFS_CON_TWO, 16'h0002);
        wr(OFS_OVERRIDE, 16'h0000);
        wr(OFS_DUTY1, 16'h0bad);
        settle(3);
        pin_chk(6'h26);
        check("da1", da1, 32'hf00f);
        run <= 1'b1;
        settle(12);
        pin_chk(6'h00);
        check("da1", da1, 32'h0bad);
        run <= 1'b0;
        wr(OFS_CON_TWO, 16'h0004);
        wr(OFS_DUTY2, 16'h4321);
        settle(3);
        check("da2", da2, 32'h4321);
        run <= 1'b1;
    endtask

    task automatic t_lock;
        do_reset(1'b1);
        wr(OFS_FAULT_B, 16'h0000);
        rdchk("fb", OFS_FAULT_B, 32'h0007);
        rdchk("stat", OFS_STATUS, 32'h0008);
        wr(OFS_KEY, K1);
        wr(OFS_KEY, K2);
        rdchk("stat", OFS_STATUS, 32'h0009);
        wr(OFS_FAULT_B, 16'h0001);
        rdchk("fb", OFS_FAULT_B, 32'h0001);
        wr(OFS_FAULT_B, 16'h0003);
        rdchk("fb", OFS_FAULT_B, 32'h0001);
        wr(OFS_CON_ONE, 16'h0777);
        rdchk("con1", OFS_CON_ONE, 32'h0);
        wr(OFS_DUTY3, 16'h7777);
        rdchk("dc3", OFS_DUTY3, 32'h7777);
        settle(10);
        check("da3", da3, 32'h7777);
    endtask

    initial
    begin
        do_reset(1'b0);
        t_reset();
        t_bits();
        t_manual();
        t_fault();
        t_sync();
        t_lock();
        complete_run();
    end
endmodule // test_pfodl_top
